// *** lvds_link.sv ***
// seven-to-one serial link: transmitter and receiver logic of the device
`timescale 1ns/1ps
`default_nettype none
`include "lvds_link_defines.svh"

module lvds_link
  import lvds_link_pkg::*;
#(
  parameter int unsigned TX_LOCK_CYCLES = `TX_LOCK_CYCLES,
  parameter int unsigned RX_LOCK_CYCLES = `RX_LOCK_CYCLES
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // transmitter parallel side (pins)
  input wire lvds_link_pkg::word_t i_parallel_word_in,
  input wire logic i_parallel_clock_in,
  input wire logic i_tx_power_down_n,
  output logic o_word_ready,
  // transmitter serial side
  output lvds_link_pkg::serial_tx_t o_serial_lane_out,
  // receiver serial side (pins)
  input wire lvds_link_pkg::serial_rx_t i_serial_lane_in,
  input wire logic i_rx_power_down_n,
  // receiver parallel side
  output lvds_link_pkg::word_t o_parallel_word_out,
  output logic o_recovered_strobe_out,
  output logic o_rx_locked
);
  import lvds_link_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  word_t tx_word_s;
  logic tx_pclk_s;
  logic tx_pd_n_s;
  serial_rx_t rx_s;
  logic rx_pd_n_s;

  sync2 #(.WIDTH(`WORD_W + 2)) u_tx_sync (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_async({i_parallel_word_in, i_parallel_clock_in, i_tx_power_down_n}),
    .o_sync({tx_word_s, tx_pclk_s, tx_pd_n_s})
  );

  sync2 #(.WIDTH(`LANES + 2)) u_rx_sync (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_async({i_serial_lane_in, i_rx_power_down_n}),
    .o_sync({rx_s, rx_pd_n_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // transmitter: lock, capture and buffering

  logic tx_pclk_d_r;
  logic tx_clock_seen_r;
  logic [31:0] tx_lock_cnt_r;
  logic tx_locked_r;
  logic tx_run;
  logic tx_pclk_rise;
  logic fifo_ready;
  logic fifo_valid;
  word_t fifo_data;
  logic capture;
  logic load;

  assign tx_pclk_rise = tx_pclk_s && !tx_pclk_d_r;
  assign tx_run = tx_locked_r && tx_pd_n_s;
  // capture only while running; the source must watch o_word_ready
  assign capture = tx_pclk_rise && tx_run;
  assign o_word_ready = fifo_ready && tx_run;

  always_ff @(posedge i_clock) begin
    if (i_srst || !tx_pd_n_s) begin
      tx_pclk_d_r <= 1'b0;
      tx_clock_seen_r <= 1'b0;
      tx_lock_cnt_r <= '0;
      tx_locked_r <= 1'b0;
    end else begin
      tx_pclk_d_r <= tx_pclk_s;
      if (tx_pclk_rise) begin
        tx_clock_seen_r <= 1'b1;
      end
      // lock settles a fixed time after the parallel clock appears
      if (tx_clock_seen_r && !tx_locked_r) begin
        tx_lock_cnt_r <= tx_lock_cnt_r + 32'h1;
        tx_locked_r <= (tx_lock_cnt_r == TX_LOCK_CYCLES - 32'h1);
      end
    end
  end

  // words queued before a power-down are stale afterwards, so flush
  word_fifo #(.WIDTH(`WORD_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_clear(!tx_pd_n_s),
    .i_valid(capture),
    .o_ready(fifo_ready),
    .i_data(tx_word_s),
    .o_valid(fifo_valid),
    .i_ready(load),
    .o_data(fifo_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // transmitter: serializer

  frame_t tx_frame_r;
  slot_t tx_slot_r;
  logic tx_busy_r;
  serial_tx_t tx_out_r;
  lane_bits_t tx_lane_bits;

  assign load = fifo_valid && tx_run && (!tx_busy_r || tx_slot_r == `SLOT_LAST);

  // lane l, slot s carries word bit l*7+s
  always_comb begin
    for (int l = 0; l < `LANES; l++) begin
      tx_lane_bits[l] = tx_frame_r[l][tx_slot_r];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      tx_frame_r <= '0;
      tx_slot_r <= '0;
      tx_busy_r <= 1'b0;
    end else if (load) begin
      tx_frame_r <= frame_t'(fifo_data);
      tx_slot_r <= '0;
      tx_busy_r <= 1'b1;
    end else if (tx_busy_r) begin
      tx_slot_r <= tx_slot_r + 3'h1;
      tx_busy_r <= (tx_slot_r != `SLOT_LAST);
    end
  end

  // the forwarded clock runs only while frames flow, as it is made from the
  // serializer slot count; it is high for slots 0-3 and low for 4-6
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      tx_out_r <= '0;
    end else begin
      tx_out_r.lane <= tx_busy_r ? tx_lane_bits : '0;
      tx_out_r.fwd_clock <= tx_busy_r && (tx_slot_r < `FWD_HIGH_SLOTS);
      tx_out_r.oe <= tx_pd_n_s;
    end
  end

  assign o_serial_lane_out = tx_out_r;

  ////////////////////////////////////////////////////////////////////////////
  // receiver: clock recovery and lock

  logic rx_fwd_d_r;
  logic rx_rise;
  logic rx_clock_seen_r;
  logic [31:0] rx_lock_cnt_r;
  logic rx_locked_r;
  logic rx_active;

  assign rx_rise = rx_s.fwd_clock && !rx_fwd_d_r;
  assign rx_active = rx_locked_r && rx_pd_n_s;

  always_ff @(posedge i_clock) begin
    if (i_srst || !rx_pd_n_s) begin
      rx_fwd_d_r <= 1'b0;
      rx_clock_seen_r <= 1'b0;
      rx_lock_cnt_r <= '0;
      rx_locked_r <= 1'b0;
    end else begin
      rx_fwd_d_r <= rx_s.fwd_clock;
      if (rx_rise) begin
        rx_clock_seen_r <= 1'b1;
      end
      if (rx_clock_seen_r && !rx_locked_r) begin
        rx_lock_cnt_r <= rx_lock_cnt_r + 32'h1;
        rx_locked_r <= (rx_lock_cnt_r == RX_LOCK_CYCLES - 32'h1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver: slot sampler and output word

  slot_t rx_slot_r;
  slot_t rx_idx;
  logic rx_sample;
  logic rx_done;
  logic rx_done_r;
  frame_t rx_frame_r;
  word_t rx_word_r;
  logic [`STROBE_DELAY-1:0] rx_strobe_line_r;
  logic rx_strobe_r;

  // slot 0 lines up with the forwarded clock rise, one slot per cycle after
  assign rx_idx = rx_rise ? '0 : rx_slot_r;
  assign rx_sample = rx_rise || (rx_slot_r != `SLOT_IDLE);
  assign rx_done = rx_sample && (rx_idx == `SLOT_LAST);

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rx_slot_r <= `SLOT_IDLE;
      rx_frame_r <= '0;
      rx_done_r <= 1'b0;
    end else begin
      rx_done_r <= rx_done;
      if (rx_sample) begin
        rx_slot_r <= (rx_idx == `SLOT_LAST) ? `SLOT_IDLE : rx_idx + 3'h1;
        for (int l = 0; l < `LANES; l++) begin
          rx_frame_r[l][rx_idx] <= rx_s.lane[l];
        end
      end
    end
  end

  // strobe is the forwarded clock delayed so its rise lands two cycles
  // after the word updates; its period therefore follows the link
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rx_word_r <= '0;
      rx_strobe_line_r <= '0;
      rx_strobe_r <= 1'b0;
    end else begin
      rx_strobe_line_r <= {rx_strobe_line_r[`STROBE_DELAY-2:0], rx_s.fwd_clock};
      rx_strobe_r <= rx_active && rx_strobe_line_r[`STROBE_DELAY-1];
      if (!rx_active) begin
        rx_word_r <= '0;
      end else if (rx_done_r) begin
        rx_word_r <= word_t'(rx_frame_r);
      end
    end
  end

  assign o_parallel_word_out = rx_word_r;
  assign o_recovered_strobe_out = rx_strobe_r;
  assign o_rx_locked = rx_locked_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_tx_capture;
    @(posedge i_clock) disable iff (i_srst)
    (tx_pclk_rise && tx_run && fifo_ready) |=> (u_fifo.count_r != '0);
  endproperty
  a_tx_capture: assert property (p_tx_capture) else $error("parallel word not captured");

  sequence s_frame_start;
    load;
  endsequence
  sequence s_seven_slots;
    ##1 (tx_slot_r == 3'h0) ##1 (tx_slot_r == 3'h1) ##5 (tx_slot_r == `SLOT_LAST);
  endsequence
  property p_slot_run;
    @(posedge i_clock) disable iff (i_srst)
    s_frame_start |-> s_seven_slots;
  endproperty
  a_slot_run: assert property (p_slot_run) else $error("frame not seven slots");

  property p_lane_bits;
    @(posedge i_clock) disable iff (i_srst)
    (tx_busy_r && tx_slot_r == 3'h0) |=>
      (o_serial_lane_out.lane == {$past(tx_frame_r[2][0]), $past(tx_frame_r[1][0]),
                                  $past(tx_frame_r[0][0])});
  endproperty
  a_lane_bits: assert property (p_lane_bits) else $error("lane slot 0 wrong");

  property p_fwd_clock;
    @(posedge i_clock) disable iff (i_srst)
    load |=> ##1 o_serial_lane_out.fwd_clock [*4] ##1 !o_serial_lane_out.fwd_clock;
  endproperty
  a_fwd_clock: assert property (p_fwd_clock) else $error("forwarded clock shape wrong");

  property p_tx_power_down;
    @(posedge i_clock) disable iff (i_srst)
    !i_tx_power_down_n [*4] |-> !o_serial_lane_out.oe;
  endproperty
  a_tx_power_down: assert property (p_tx_power_down) else $error("tx not floated");

  property p_tx_pd_delay;
    @(posedge i_clock) disable iff (i_srst)
    $fell(i_tx_power_down_n) ##1 !i_tx_power_down_n [*3] |-> ##[0:6] !o_serial_lane_out.oe;
  endproperty
  a_tx_pd_delay: assert property (p_tx_pd_delay) else $error("tx power-down too slow");

  property p_rx_pd_delay;
    @(posedge i_clock) disable iff (i_srst)
    $fell(i_rx_power_down_n) ##1 !i_rx_power_down_n [*3] |->
      ##[0:96] (o_parallel_word_out == '0 && !o_recovered_strobe_out);
  endproperty
  a_rx_pd_delay: assert property (p_rx_pd_delay) else $error("rx power-down too slow");

  property p_rx_unlocked_low;
    @(posedge i_clock) disable iff (i_srst)
    !rx_locked_r |=> (o_parallel_word_out == '0);
  endproperty
  a_rx_unlocked_low: assert property (p_rx_unlocked_low) else $error("rx output before lock");

  // an idle serializer must not start a frame while the lock timer runs
  property p_tx_no_frame_unlocked;
    @(posedge i_clock) disable iff (i_srst)
    (!tx_locked_r && !tx_busy_r) |=> !tx_busy_r;
  endproperty
  a_tx_no_frame_unlocked: assert property (p_tx_no_frame_unlocked) else $error("frame before lock");

  property p_rx_strobe;
    @(posedge i_clock) disable iff (i_srst)
    (rx_done_r && rx_active) ##1 rx_active ##1 rx_active |=> $rose(o_recovered_strobe_out);
  endproperty
  a_rx_strobe: assert property (p_rx_strobe) else $error("strobe not after word");
endmodule // lvds_link

`default_nettype wire

// *** lvds_link_defines.svh ***
// constants for the seven-to-one serial link: widths, slot layout and timing counts
`ifndef LVDS_LINK_DEFINES_SVH
`define LVDS_LINK_DEFINES_SVH

`define WORD_W 21
`define LANES 3
`define SLOTS 7
`define SLOT_W 3
`define SLOT_LAST 3'h6
`define SLOT_IDLE 3'h7
`define FWD_HIGH_SLOTS 3'h4
`define FIFO_DEPTH 16
`define STROBE_DELAY 9

`define CLK_PERIOD_PS 10000
`define TX_PD_DELAY_NS 100
`define TX_PD_CYCLES ((`TX_PD_DELAY_NS * 1000) / `CLK_PERIOD_PS)
`define RX_PD_DELAY_US 1
`define RX_PD_CYCLES ((`RX_PD_DELAY_US * 1000000) / `CLK_PERIOD_PS)
`define TX_LOCK_TIME_MS 10
`define TX_LOCK_CYCLES (32'((`TX_LOCK_TIME_MS * 64'd1000000000) / `CLK_PERIOD_PS))
`define RX_LOCK_TIME_MS 10
`define RX_LOCK_CYCLES (32'((`RX_LOCK_TIME_MS * 64'd1000000000) / `CLK_PERIOD_PS))
`define RX_BIT0_POS_PS 1100
`define RX_BIT6_POS_PS 14300
`define RX_SLOT_SPACING_PS ((`RX_BIT6_POS_PS - `RX_BIT0_POS_PS) / (`SLOTS - 1))

`endif

// *** lvds_link_pkg.sv ***
// types shared by the serial link files
`include "lvds_link_defines.svh"

package lvds_link_pkg;
  typedef logic [`WORD_W-1:0] word_t;
  typedef logic [`SLOTS-1:0] slot_bits_t;
  typedef slot_bits_t [`LANES-1:0] frame_t;
  typedef logic [`LANES-1:0] lane_bits_t;
  typedef logic [`SLOT_W-1:0] slot_t;
  typedef struct packed {
    lane_bits_t lane;
    logic fwd_clock;
    logic oe;
  } serial_tx_t;
  typedef struct packed {
    lane_bits_t lane;
    logic fwd_clock;
  } serial_rx_t;
endpackage

// *** sync2.sv ***
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // asynchronous input and its synchronised copy
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;
endmodule // sync2

`default_nettype wire

// *** word_fifo.sv ***
// synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock, reset and flush
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_clear,
  // fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign o_ready = (count_r != (AW+1)'(DEPTH));
  assign o_valid = (count_r != '0);
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_data = mem[rd_r];

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_r] <= i_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst || i_clear) begin
      wr_r <= '0;
      rd_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // word_fifo

`default_nettype wire

// *** link_far_end.sv ***
// far-end model: decodes the transmitter lanes and serialises words for the receiver
`timescale 1ns/1ps
`default_nettype none

module link_far_end (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // transmitter lanes and the word decoded from them
  input wire lvds_link_pkg::serial_tx_t i_tx_serial,
  output lvds_link_pkg::word_t o_word,
  output logic o_word_valid,
  output logic o_frame_error,
  // word to send towards the receiver
  input wire logic i_send,
  input wire lvds_link_pkg::word_t i_send_word,
  output logic o_send_ready,
  output lvds_link_pkg::serial_rx_t o_rx_serial
);
  import lvds_link_pkg::*;
  logic fwd_prev_r;
  logic [2:0] rx_slot_r;
  logic [2:0] tx_slot_r;
  word_t tx_word_r;
  wire logic fwd_now = i_tx_serial.oe & i_tx_serial.fwd_clock;
  wire logic [2:0] cur_slot = (fwd_now & ~fwd_prev_r) ? 3'h0 : rx_slot_r;
  assign o_send_ready = (tx_slot_r == 3'h7) || (tx_slot_r == 3'h6);

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      fwd_prev_r <= 1'b0;
      rx_slot_r <= 3'h7;
      o_word_valid <= 1'b0;
      o_frame_error <= 1'b0;
      o_word <= '0;
    end else begin
      fwd_prev_r <= fwd_now;
      o_word_valid <= (cur_slot == 3'h6);
      if (cur_slot != 3'h7) begin
        for (int l = 0; l < 3; l++) o_word[l * 7 + int'(cur_slot)] <= i_tx_serial.lane[l];
        // clock high in slots 0-3 only, and the pins must be driven all frame
        if (fwd_now != (cur_slot < 3'h4) || !i_tx_serial.oe) o_frame_error <= 1'b1;
        rx_slot_r <= (cur_slot == 3'h6) ? 3'h7 : cur_slot + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      tx_slot_r <= 3'h7;
      tx_word_r <= '0;
      o_rx_serial <= '0;
    end else if (i_send && o_send_ready) begin
      tx_word_r <= i_send_word;
      tx_slot_r <= 3'h0;
      o_rx_serial.fwd_clock <= 1'b1;
      for (int l = 0; l < 3; l++) o_rx_serial.lane[l] <= i_send_word[l * 7];
    end else if (tx_slot_r < 3'h6) begin
      tx_slot_r <= tx_slot_r + 3'h1;
      o_rx_serial.fwd_clock <= (tx_slot_r + 3'h1) < 3'h4;
      for (int l = 0; l < 3; l++) o_rx_serial.lane[l] <= tx_word_r[l * 7 + int'(tx_slot_r) + 1];
    end else begin
      // clock stands still between frames; idle lanes toggle so no stale bit looks valid
      tx_slot_r <= 3'h7;
      o_rx_serial.fwd_clock <= 1'b0;
      o_rx_serial.lane <= ~o_rx_serial.lane;
    end
  end
endmodule // link_far_end

`default_nettype wire

// *** lvds_link_tb_top.sv ***
// self-checking testbench for the seven-to-one serial link
`timescale 1ns/1ps
`default_nettype none

module lvds_link_tb_top;
  import lvds_link_pkg::*;
  logic clk, srst, pclk, tx_pd_n, rx_pd_n, send, far_valid, far_err, send_ready;
  logic word_ready, strobe, locked, ignore_rx, burst, full_seen;
  word_t par_word, send_word, far_word, rx_word;
  serial_tx_t ser_out;
  serial_rx_t ser_in;
  int n_mismatch, n_tests, n_rx, n_cyc, t0;
  logic [15:0] lfsr;
  word_t exp_q[$];
  word_t rx_w[6];

  lvds_link #(.TX_LOCK_CYCLES(20), .RX_LOCK_CYCLES(20)) lvds_link_inst (
    .i_clock(clk), .i_srst(srst), .i_parallel_word_in(par_word), .i_parallel_clock_in(pclk),
    .i_tx_power_down_n(tx_pd_n), .o_word_ready(word_ready), .o_serial_lane_out(ser_out),
    .i_serial_lane_in(ser_in), .i_rx_power_down_n(rx_pd_n), .o_parallel_word_out(rx_word),
    .o_recovered_strobe_out(strobe), .o_rx_locked(locked));
  link_far_end link_far_end_inst (
    .i_clock(clk), .i_srst(srst), .i_tx_serial(ser_out), .o_word(far_word),
    .o_word_valid(far_valid), .o_frame_error(far_err), .i_send(send),
    .i_send_word(send_word), .o_send_ready(send_ready), .o_rx_serial(ser_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) n_cyc <= n_cyc + 1;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic timeout(input string what);
    $display("wrong value at %0t: no %s in time", $time, what);
    n_mismatch++;
    give_verdict();
  endtask

  task automatic wait_high(ref logic sig, input int bound, input string what);
    int k;
    k = 0;
    while (sig !== 1'b1) begin
      @(negedge clk);
      k++;
      if (k > bound) timeout(what);
    end
  endtask

  function automatic word_t rand_word();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    rand_word = {lfsr[4:0], lfsr};
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
  endfunction

  task automatic tx_word(input word_t w);
    wait_high(word_ready, 200, "word ready");
    par_word = w;
    pclk = 1'b1;
    exp_q.push_back(w);
    repeat (4) @(negedge clk);
    pclk = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  // leaves send high so the next call can follow back to back
  task automatic send_frame(input word_t w);
    @(negedge clk);
    send = 1'b1;
    send_word = w;
    wait_high(send_ready, 20, "send ready");
    @(posedge clk);
  endtask

  task automatic wait_strobe();
    logic prev;
    int k;
    prev = strobe;
    k = 0;
    @(negedge clk);
    while (!(strobe === 1'b1 && prev === 1'b0)) begin
      prev = strobe;
      @(negedge clk);
      k++;
      if (k > 40) timeout("strobe");
    end
  endtask

  // in burst mode words refused by a full buffer are skipped
  always @(negedge clk) begin
    if (far_valid === 1'b1 && !ignore_rx) begin
      while (burst && exp_q.size() > 1 && exp_q[0] !== far_word) void'(exp_q.pop_front());
      n_rx++;
      if (exp_q.size() == 0) check(1, 0, "unexpected word");
      else check(far_word, exp_q.pop_front(), "tx word");
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    pclk = 1'b0;
    par_word = '0;
    tx_pd_n = 1'b1;
    rx_pd_n = 1'b1;
    send = 1'b0;
    send_word = '0;
    ignore_rx = 1'b0;
    burst = 1'b0;
    full_seen = 1'b0;
    lfsr = 16'h0041;
    n_mismatch = 0;
    n_tests = 0;
    n_rx = 0;
    n_cyc = 0;
    repeat (8) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    check({ser_out.oe, rx_word, strobe, locked, word_ready}, 0, "after reset");
    $display("test reset done");
    repeat (2) begin
      pclk = 1'b1;
      par_word = rand_word();
      repeat (4) @(negedge clk);
      pclk = 1'b0;
      check(word_ready, 0, "ready before lock");
      repeat (4) @(negedge clk);
    end
    wait_high(word_ready, 100, "tx lock");
    check(n_rx, 0, "words before lock");
    tx_word(21'h0);
    tx_word(21'h1FFFFF);
    for (int i = 0; i < 12; i++) tx_word(rand_word());
    repeat (20) @(negedge clk);
    check(exp_q.size(), 0, "words lost");
    $display("test tx stream done");
    burst = 1'b1;
    t0 = n_rx;
    for (int i = 0; i < 30; i++) begin
      par_word = rand_word();
      pclk = 1'b1;
      exp_q.push_back(par_word);
      @(negedge clk);
      pclk = 1'b0;
      if (word_ready === 1'b0) full_seen = 1'b1;
      @(negedge clk);
    end
    repeat (250) @(negedge clk);
    check({full_seen, n_rx - t0 >= 16, n_rx - t0 < 30}, 3'h7, "buffer fill");
    check(far_err, 0, "fwd clock shape");
    exp_q.delete();
    burst = 1'b0;
    $display("test burst done");
    send_frame(rand_word());
    send_frame(rand_word());
    @(negedge clk);
    send = 1'b0;
    repeat (12) @(negedge clk);
    check(rx_word, 0, "word before lock");
    wait_high(locked, 40, "rx lock");
    for (int i = 0; i < 6; i++) rx_w[i] = (i == 0) ? 21'h1FFFFF : (i == 1) ? 21'h0 : rand_word();
    fork
      begin
        for (int i = 0; i < 6; i++) send_frame(rx_w[i]);
        @(negedge clk);
        send = 1'b0;
      end
      for (int i = 0; i < 6; i++) begin
        wait_strobe();
        check(rx_word, rx_w[i], "rx word");
        if (i > 0) check(n_cyc - t0, 7, "strobe period");
        t0 = n_cyc;
      end
    join
    $display("test rx stream done");
    rx_pd_n = 1'b0;
    fork
      begin
        for (int i = 0; i < 3; i++) send_frame(rand_word());
        @(negedge clk);
        send = 1'b0;
      end
      begin
        repeat (100) @(negedge clk);
        check({rx_word, strobe, locked}, 0, "rx power-down");
      end
    join
    rx_pd_n = 1'b1;
    send_frame(rx_w[0]);
    @(negedge clk);
    send = 1'b0;
    repeat (15) @(negedge clk);
    check({rx_word, locked}, 0, "word after wake");
    $display("test rx power-down done");
    ignore_rx = 1'b1;
    fork
      tx_word(rand_word());
      begin
        repeat (6) @(negedge clk);
        tx_pd_n = 1'b0;
        repeat (10) @(negedge clk);
        check({ser_out.oe, word_ready}, 0, "tx power-down");
      end
    join
    $display("test tx power-down done");
    give_verdict();
  end
endmodule // lvds_link_tb_top

`default_nettype wire
